//--- hdl/fps_defs.svh
// register indices, field positions, command codes and scenario table
// assumes byte addressing on the register bus, one 32-bit word per register
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

// register indices, byte address is four times the index
`define FPS_IDX_CONFIG     4'h3
`define FPS_IDX_PROTECT    4'h4
`define FPS_IDX_STATUS     4'h5

// config fields
`define FPS_CFG_BUFFER_EMPTY_IRQ_ENABLE      7
`define FPS_CFG_COMPLETE_IRQ_ENABLE       6
`define FPS_CFG_RESET      8'h00

// protection config fields
`define FPS_PROT_POL       7
`define FPS_PROT_HDIS      5
`define FPS_PROT_HS_HI     4
`define FPS_PROT_HS_LO     3
`define FPS_PROT_LDIS      2
`define FPS_PROT_LS_HI     1
`define FPS_PROT_LS_LO     0
`define FPS_PROT_RESET     8'hA4
`define FPS_PROT_WMASK     8'hBF

// status fields
`define FPS_ST_CBE         7
`define FPS_ST_CC          6
`define FPS_ST_PROTECTION_VIOLATION_FLAG       5
`define FPS_ST_ACCESS_ERROR_FLAG      4
`define FPS_ST_BLANK       2
`define FPS_ST_FAIL        1
`define FPS_ST_DONE        0

// range limits
`define FPS_HIGH_START0    16'hF800
`define FPS_HIGH_START1    16'hF000
`define FPS_HIGH_START2    16'hE000
`define FPS_HIGH_START3    16'hC000
`define FPS_LOW_START      16'h4000
`define FPS_LOW_END0       16'h43FF
`define FPS_LOW_END1       16'h47FF
`define FPS_LOW_END2       16'h4FFF
`define FPS_LOW_END3       16'h5FFF

// command codes
`define FPS_CMD_VERIFY     8'h05
`define FPS_CMD_PROGRAM    8'h20
`define FPS_CMD_SECTOR     8'h40
`define FPS_CMD_MASS       8'h41

// allowed targets per source scenario, bit n set means scenario n allowed
`define FPS_ALLOW_FROM0    8'h0F
`define FPS_ALLOW_FROM1    8'h0A
`define FPS_ALLOW_FROM2    8'h0C
`define FPS_ALLOW_FROM3    8'h08
`define FPS_ALLOW_FROM4    8'h18
`define FPS_ALLOW_FROM5    8'h30
`define FPS_ALLOW_FROM6    8'h5A
`define FPS_ALLOW_FROM7    8'hFF

`endif

//--- hdl/fps_pkg.sv
// types shared by the protection and status logic
// assumes fps_defs.svh for all numeric constants except the sequence state codes, which are set here
package fps_pkg;

  typedef logic [2:0] fps_scenario_type;

  typedef enum logic [1:0] {
    FPS_SEQ_IDLE = 2'b00,
    FPS_SEQ_ADDR = 2'b01,
    FPS_SEQ_CMD  = 2'b10
  } fps_seq_type;

endpackage : fps_pkg

//--- hdl/fps_range_check.sv
// address protection check against the protection config
// assumes config and address stable within the cycle, pure combinational
`timescale 1ns/1ps
`include "fps_defs.svh"

module fps_range_check
  import fps_pkg::*;
(
  input  wire logic [7:0]  protCfg,
  input  wire logic [15:0] addr,
  output      logic        isProtected
);

  logic [15:0] highStart;
  logic [15:0] lowEnd;
  logic        inHigh;
  logic        inLow;
  logic        hiSel;
  logic        loSel;

  always_comb begin
    unique case (protCfg[`FPS_PROT_HS_HI:`FPS_PROT_HS_LO])
      2'b00: highStart = `FPS_HIGH_START0;
      2'b01: highStart = `FPS_HIGH_START1;
      2'b10: highStart = `FPS_HIGH_START2;
      2'b11: highStart = `FPS_HIGH_START3;
    endcase
    unique case (protCfg[`FPS_PROT_LS_HI:`FPS_PROT_LS_LO])
      2'b00: lowEnd = `FPS_LOW_END0;
      2'b01: lowEnd = `FPS_LOW_END1;
      2'b10: lowEnd = `FPS_LOW_END2;
      2'b11: lowEnd = `FPS_LOW_END3;
    endcase
  end

  assign inHigh = (addr >= highStart);
  assign inLow  = (addr >= `FPS_LOW_START) && (addr <= lowEnd);
  assign hiSel  = !protCfg[`FPS_PROT_HDIS] && inHigh;
  assign loSel  = !protCfg[`FPS_PROT_LDIS] && inLow;

  // polarity 1: selected ranges protected; polarity 0: selected ranges are the only open ones
  assign isProtected = protCfg[`FPS_PROT_POL] ? (hiSel || loSel)
                                              : !(hiSel || loSel);

endmodule : fps_range_check

//--- hdl/fps_scenario_check.sv
// decides whether a protection scenario change is allowed
// assumes scenario codes {polarity, high disable, low disable}
`timescale 1ns/1ps
`include "fps_defs.svh"

module fps_scenario_check
  import fps_pkg::*;
(
  input  wire fps_scenario_type fromScn,
  input  wire fps_scenario_type toScn,
  output      logic             allowed
);

  logic [7:0] allowRow;

  always_comb begin
    unique case (fromScn)
      3'd0: allowRow = `FPS_ALLOW_FROM0;
      3'd1: allowRow = `FPS_ALLOW_FROM1;
      3'd2: allowRow = `FPS_ALLOW_FROM2;
      3'd3: allowRow = `FPS_ALLOW_FROM3;
      3'd4: allowRow = `FPS_ALLOW_FROM4;
      3'd5: allowRow = `FPS_ALLOW_FROM5;
      3'd6: allowRow = `FPS_ALLOW_FROM6;
      3'd7: allowRow = `FPS_ALLOW_FROM7;
    endcase
  end

  assign allowed = allowRow[toScn];

endmodule : fps_scenario_check

//--- hdl/fps_flash_protect_status.sv
// protection config and status flags of the flash command controller
// assumes command engine, nonvolatile loader and cpu events on the same clock
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "fps_defs.svh"

module fps_flash_protect_status
  import fps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  input  wire logic        specialMode,
  input  wire logic        nvLoad,
  input  wire logic [7:0]  nvProtValue,
  input  wire logic        flashWrite,
  input  wire logic [15:0] flashAddr,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdCode,
  input  wire logic        stopReq,
  input  wire logic        cmdFetch,
  input  wire logic        allDone,
  input  wire logic        opActive,
  input  wire logic        verifyDone,
  input  wire logic        verifyErased,
  output      logic        cmdLaunch,
  output      logic [7:0]  launchCmd,
  output      logic [15:0] launchAddr,
  output      logic        bufferEmptyIrq,
  output      logic        completeIrq
);

  // ==========================================================
  // register bus handshake
  logic        waitReqFF;
  logic [31:0] readDataFF;
  logic        wrAct;
  logic [3:0]  regIdx;
  logic        wrCfg;
  logic        wrProt;
  logic        wrStat;

  assign wrAct  = write && !waitReqFF && byteenable[0] && (address[1:0] == 2'b00);
  assign regIdx = address[5:2];
  assign wrCfg  = wrAct && (regIdx == `FPS_IDX_CONFIG);
  assign wrProt = wrAct && (regIdx == `FPS_IDX_PROTECT);
  assign wrStat = wrAct && (regIdx == `FPS_IDX_STATUS);

  // one cycle of waitrequest high, then low for one edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitReqFF <= 1'b1;
    end else if (ce) begin
      waitReqFF <= !((read || write) && waitReqFF);
    end
  end

  // ==========================================================
  // protection config
  logic [7:0]       protFF;
  logic [7:0]       nxt_prot;
  fps_scenario_type curScn;
  fps_scenario_type reqScn;
  logic             scnOk;

  assign curScn = {protFF[`FPS_PROT_POL], protFF[`FPS_PROT_HDIS], protFF[`FPS_PROT_LDIS]};

  always_comb begin
    nxt_prot = writedata[7:0] & `FPS_PROT_WMASK;
    if (!protFF[`FPS_PROT_HDIS]) begin
      nxt_prot[`FPS_PROT_HS_HI:`FPS_PROT_HS_LO] = protFF[`FPS_PROT_HS_HI:`FPS_PROT_HS_LO];
    end
    if (!protFF[`FPS_PROT_LDIS]) begin
      nxt_prot[`FPS_PROT_LS_HI:`FPS_PROT_LS_LO] = protFF[`FPS_PROT_LS_HI:`FPS_PROT_LS_LO];
    end
  end

  assign reqScn = {nxt_prot[`FPS_PROT_POL], nxt_prot[`FPS_PROT_HDIS], nxt_prot[`FPS_PROT_LDIS]};

  fps_scenario_check u_scn (
    .fromScn (curScn),
    .toScn   (reqScn),
    .allowed (scnOk)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      protFF <= `FPS_PROT_RESET;
    end else if (ce) begin
      if (nvLoad) begin
        protFF <= nvProtValue & `FPS_PROT_WMASK;
      end else if (wrProt && scnOk) begin
        protFF <= nxt_prot;
      end
    end
  end

  // ==========================================================
  // config register
  logic [7:0] cfgFF;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfgFF <= `FPS_CFG_RESET;
    end else if (ce && wrCfg) begin
      cfgFF <= {writedata[`FPS_CFG_BUFFER_EMPTY_IRQ_ENABLE], writedata[`FPS_CFG_COMPLETE_IRQ_ENABLE], 6'h00};
    end
  end

  // ==========================================================
  // command write sequence
  fps_seq_type seqFF;
  logic [15:0] seqAddrFF;
  logic [7:0]  seqCmdFF;
  logic        cbeFF;
  logic        ccFF;
  logic        pviolFF;
  logic        accerrFF;
  logic        blankFF;
  logic        failFF;
  logic        addrProt;
  logic        cmdLegal;
  logic        cmdModifies;
  logic        errBlock;
  logic        wrCbeOne;
  logic        wrCbeZero;
  logic        launchOk;
  logic        seqAbort;
  logic        cmdViol;
  logic        seqFault;
  logic        stopFault;

  fps_range_check u_range (
    .protCfg     (protFF),
    .addr        (seqAddrFF),
    .isProtected (addrProt)
  );

  assign cmdLegal    = (cmdCode == `FPS_CMD_VERIFY) || (cmdCode == `FPS_CMD_PROGRAM) ||
                       (cmdCode == `FPS_CMD_SECTOR) || (cmdCode == `FPS_CMD_MASS);
  assign cmdModifies = (cmdCode == `FPS_CMD_PROGRAM) || (cmdCode == `FPS_CMD_SECTOR) ||
                       (cmdCode == `FPS_CMD_MASS);
  assign errBlock    = pviolFF || accerrFF || failFF;
  assign wrCbeOne    = wrStat && writedata[`FPS_ST_CBE];
  assign wrCbeZero   = wrStat && !writedata[`FPS_ST_CBE];
  assign launchOk    = wrCbeOne && (seqFF == FPS_SEQ_CMD) && !errBlock && cbeFF;
  assign seqAbort    = wrCbeZero && (seqFF != FPS_SEQ_IDLE);
  assign cmdViol     = cmdWrite && (seqFF == FPS_SEQ_ADDR) && cmdLegal && cmdModifies && addrProt;
  assign seqFault    = (cmdWrite && (seqFF != FPS_SEQ_ADDR)) ||
                       (cmdWrite && (seqFF == FPS_SEQ_ADDR) && !cmdLegal) ||
                       (flashWrite && (seqFF == FPS_SEQ_CMD)) ||
                       (wrCbeOne && (seqFF == FPS_SEQ_ADDR));
  assign stopFault   = stopReq && !ccFF;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seqFF     <= FPS_SEQ_IDLE;
      seqAddrFF <= 16'h0000;
      seqCmdFF  <= 8'h00;
    end else if (ce) begin
      unique case (seqFF)
        FPS_SEQ_IDLE: begin
          if (flashWrite && !errBlock) begin
            seqFF     <= FPS_SEQ_ADDR;
            seqAddrFF <= flashAddr;
          end
        end
        FPS_SEQ_ADDR: begin
          if (seqAbort || seqFault || cmdViol) begin
            seqFF <= FPS_SEQ_IDLE;
          end else if (cmdWrite) begin
            seqFF    <= FPS_SEQ_CMD;
            seqCmdFF <= cmdCode;
          end
        end
        FPS_SEQ_CMD: begin
          if (launchOk || seqAbort || seqFault || errBlock) begin
            seqFF <= FPS_SEQ_IDLE;
          end
        end
        default: begin
          seqFF <= FPS_SEQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // launch to command engine
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmdLaunch  <= 1'b0;
      launchCmd  <= 8'h00;
      launchAddr <= 16'h0000;
    end else if (ce) begin
      cmdLaunch <= launchOk;
      if (launchOk) begin
        launchCmd  <= seqCmdFF;
        launchAddr <= seqAddrFF;
      end
    end
  end

  // ==========================================================
  // status flags, a set in the same cycle as a clear wins, except ccFF where a launch beats allDone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cbeFF <= 1'b1;
    end else if (ce) begin
      if (cmdFetch) begin
        cbeFF <= 1'b1;
      end else if (launchOk) begin
        cbeFF <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ccFF <= 1'b1;
    end else if (ce) begin
      if (allDone && !launchOk) begin
        ccFF <= 1'b1;
      end else if (launchOk) begin
        ccFF <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pviolFF <= 1'b0;
    end else if (ce) begin
      if (cmdViol) begin
        pviolFF <= 1'b1;
      end else if (wrStat && writedata[`FPS_ST_PROTECTION_VIOLATION_FLAG]) begin
        pviolFF <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accerrFF <= 1'b0;
    end else if (ce) begin
      if (seqAbort || seqFault || stopFault) begin
        accerrFF <= 1'b1;
      end else if (wrStat && writedata[`FPS_ST_ACCESS_ERROR_FLAG]) begin
        accerrFF <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blankFF <= 1'b0;
    end else if (ce) begin
      if (verifyDone && verifyErased) begin
        blankFF <= 1'b1;
      end else if (launchOk) begin
        blankFF <= 1'b0;
      end
    end
  end

  // software must clear this before a new sequence, else launches stay blocked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      failFF <= 1'b0;
    end else if (ce) begin
      if (specialMode && verifyDone && !verifyErased) begin
        failFF <= 1'b1;
      end else if (specialMode && wrStat && writedata[`FPS_ST_FAIL]) begin
        failFF <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read data and interrupt requests
  logic [7:0] statusView;

  always_comb begin
    statusView                = 8'h00;
    statusView[`FPS_ST_CBE]    = cbeFF;
    statusView[`FPS_ST_CC]     = ccFF;
    statusView[`FPS_ST_PROTECTION_VIOLATION_FLAG]  = pviolFF;
    statusView[`FPS_ST_ACCESS_ERROR_FLAG] = accerrFF;
    statusView[`FPS_ST_BLANK]  = blankFF;
    statusView[`FPS_ST_FAIL]   = specialMode && failFF;
    statusView[`FPS_ST_DONE]   = specialMode && !opActive;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readDataFF <= 32'h0000_0000;
    end else if (ce && (read && waitReqFF)) begin
      unique case (regIdx)
        `FPS_IDX_CONFIG:  readDataFF <= {24'h00_0000, cfgFF};
        `FPS_IDX_PROTECT: readDataFF <= {24'h00_0000, protFF};
        `FPS_IDX_STATUS:  readDataFF <= {24'h00_0000, statusView};
        default:          readDataFF <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bufferEmptyIrq <= 1'b0;
      completeIrq    <= 1'b0;
    end else if (ce) begin
      bufferEmptyIrq <= cbeFF && cfgFF[`FPS_CFG_BUFFER_EMPTY_IRQ_ENABLE];
      completeIrq    <= ccFF && cfgFF[`FPS_CFG_COMPLETE_IRQ_ENABLE];
    end
  end

  assign waitrequest = waitReqFF;
  assign readdata    = readDataFF;

endmodule : fps_flash_protect_status

//--- dv/fps_flash_protect_status_properties.sv
// assertions on the bus, launch and interrupt ports of the protection and status block
// assumes binding to fps_flash_protect_status, one clock domain
`timescale 1ns/1ps

module fps_flash_protect_status_properties (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        specialMode,
  input wire logic        opActive,
  input wire logic        cmdLaunch,
  input wire logic [7:0]  launchCmd,
  input wire logic [15:0] launchAddr,
  input wire logic        bufferEmptyIrq,
  input wire logic        completeIrq
);
  // ====================
  // shared terms
  logic rdSt;
  logic rdProt;
  assign rdSt   = read && !waitrequest && address == 6'h14;
  assign rdProt = read && !waitrequest && address == 6'h10;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ====================
  // properties
  property p_wait_answer; $rose(read | write) |=> !waitrequest; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
  property p_wait_single; !waitrequest |=> waitrequest; endproperty
  a_wait_single: assert property (p_wait_single) else $error("waitrequest low too long");
  property p_upper_zero; !waitrequest |-> readdata[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("readdata upper bits set");
  property p_norm_zero;
    rdSt && !$past(specialMode) && !$past(specialMode, 2) |-> readdata[3] == 1'b0 && readdata[1:0] == 2'b00;
  endproperty
  a_norm_zero: assert property (p_norm_zero) else $error("status low bits set in normal mode");
  property p_special_done;
    rdSt && $past(specialMode) && $past(specialMode, 2) && $past(opActive) == $past(opActive, 2)
      |-> readdata[0] == !$past(opActive);
  endproperty
  a_special_done: assert property (p_special_done) else $error("done bit wrong");
  property p_prot_bit6; rdProt |-> !readdata[6]; endproperty
  a_prot_bit6: assert property (p_prot_bit6) else $error("protection bit 6 set");
  property p_launch_cause;
    cmdLaunch |-> $past(write && !waitrequest && address == 6'h14 && writedata[7]);
  endproperty
  a_launch_cause: assert property (p_launch_cause) else $error("launch without status write");
  property p_launch_stable; !cmdLaunch |-> $stable(launchCmd) && $stable(launchAddr); endproperty
  a_launch_stable: assert property (p_launch_stable) else $error("launch values moved");
  property p_irq_drop; cmdLaunch |=> !bufferEmptyIrq && !completeIrq; endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq high after launch");
endmodule : fps_flash_protect_status_properties

bind fps_flash_protect_status fps_flash_protect_status_properties i_props (
  .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .specialMode(specialMode), .opActive(opActive),
  .cmdLaunch(cmdLaunch), .launchCmd(launchCmd), .launchAddr(launchAddr),
  .bufferEmptyIrq(bufferEmptyIrq), .completeIrq(completeIrq));

//--- dv/fps_flash_protect_status_tb.sv
// self-checking bench for the flash protection and status block
// assumes the bench drives all side inputs; flags modelled in bench variables
`timescale 1ns/1ps

module fps_flash_protect_status_tb;
  localparam int FW = 0, CW = 1, STOP = 2, FETCH = 3, DONE = 4, VER = 5, NVL = 6;
  localparam logic [5:0] ST = 6'h14;
  logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, read = 1'b0, write = 1'b0;
  logic [5:0]  address = 6'h00;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, s;
  logic        waitrequest, specialMode = 1'b0, nvLoad = 1'b0, flashWrite = 1'b0, cmdWrite = 1'b0;
  logic        stopReq = 1'b0, cmdFetch = 1'b0, allDone = 1'b0, opActive = 1'b0, verifyDone = 1'b0;
  logic        verifyErased = 1'b0, cmdLaunch, bufferEmptyIrq, completeIrq;
  logic [7:0]  nvProtValue = 8'h0, cmdCode = 8'h0, launchCmd, q, f, t, g, prot = 8'hA4, cfg = 8'h0;
  logic [15:0] flashAddr = 16'h0, launchAddr, a;
  bit          cbe = 1, cc = 1, pv, ae, blank, fail;
  int          n_mismatch, n_checks, cyc;
  integer      seed = 32'h1CF5;
  logic [7:0]  allow [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h30, 8'h5A, 8'hFF};
  logic [7:0]  codes [5] = '{8'h05, 8'h20, 8'h40, 8'h41, 8'h33};

  fps_flash_protect_status i_fps_flash_protect_status (
    .clk(clk), .rstn(rstn), .ce(ce), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .specialMode(specialMode), .nvLoad(nvLoad), .nvProtValue(nvProtValue), .flashWrite(flashWrite),
    .flashAddr(flashAddr), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .stopReq(stopReq), .cmdFetch(cmdFetch),
    .allDone(allDone), .opActive(opActive), .verifyDone(verifyDone), .verifyErased(verifyErased),
    .cmdLaunch(cmdLaunch), .launchCmd(launchCmd), .launchAddr(launchAddr),
    .bufferEmptyIrq(bufferEmptyIrq), .completeIrq(completeIrq));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ====================
  // checking and bus tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [5:0] ad, input logic [7:0] d);
    @(posedge clk);
    address <= ad;
    writedata <= {24'h0, d};
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // one cycle pulse on a side strobe, data on all side data inputs
  task automatic pulse(input int k, input logic [15:0] d);
    @(posedge clk);
    {nvLoad, verifyDone, allDone, cmdFetch, stopReq, cmdWrite, flashWrite} <= 7'(1 << k);
    {flashAddr, cmdCode, nvProtValue, verifyErased} <= {d, d[7:0], d[7:0], d[0]};
    @(posedge clk);
    {nvLoad, verifyDone, allDone, cmdFetch, stopReq, cmdWrite, flashWrite} <= 7'h0;
  endtask : pulse

  task automatic rd_st();
    bus(1'b0, ST, 8'h0);
    chk("status", 16'(q), 16'({cbe, cc, pv, ae, 1'b0, blank, specialMode & fail, specialMode & !opActive}));
    chk("bufferEmptyIrq", 16'(bufferEmptyIrq), 16'(cbe & cfg[7]));
    chk("completeIrq", 16'(completeIrq), 16'(cc & cfg[6]));
  endtask : rd_st

  function automatic bit isprot(input logic [7:0] p, input logic [15:0] ad);
    logic [15:0] hs, le;
    bit          hit;
    hs = 16'hF800 << p[4:3];
    le = 16'h3FFF + (16'h0400 << p[1:0]);
    hit = (!p[5] && ad >= hs) || (!p[2] && ad >= 16'h4000 && ad <= le);
    return p[7] ? hit : !hit;
  endfunction : isprot

  task automatic run_cmd(input logic [15:0] ad, input logic [7:0] c, input bit erased);
    bit bad, hit;
    bad = !(c inside {8'h05, 8'h20, 8'h40, 8'h41});
    hit = !bad && c != 8'h05 && isprot(prot, ad);
    pulse(FW, ad);
    pulse(CW, 16'(c));
    if (bad || hit) begin
      ae = ae | bad;
      pv = pv | hit;
      rd_st();
    end else begin
      bus(1'b1, ST, 8'h80);
      @(negedge clk);
      chk("cmdLaunch", 16'(cmdLaunch), 16'h1);
      chk("launchCmd", 16'(launchCmd), 16'(c));
      chk("launchAddr", launchAddr, ad);
      {cbe, cc, blank} = 3'b000;
      @(posedge clk);
      opActive <= 1'b1;
      rd_st();
      pulse(FETCH, 16'h0);
      cbe = 1;
      rd_st();
      if (c == 8'h05) begin
        pulse(VER, 16'(erased));
        blank = erased;
        fail = !erased & specialMode;
      end
      @(posedge clk);
      opActive <= 1'b0;
      pulse(DONE, 16'h0);
      cc = 1;
      rd_st();
    end
  endtask : run_cmd

  // ====================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, 6'h0C, 8'h0);
    chk("config", 16'(q), 16'h0);
    bus(1'b0, 6'h00, 8'h0);
    chk("unmapped", 16'(q), 16'h0);
    rd_st();
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      s = $random(seed);
      f = {i[5], 1'b0, i[4], s[1:0], i[3], s[3:2]};
      t = {i[2], s[4], i[1], s[6:5], i[0], s[8:7]};
      pulse(NVL, 16'(f));
      bus(1'b1, 6'h10, t);
      g = t & 8'hBF;
      if (!f[5]) g[4:3] = f[4:3];
      if (!f[2]) g[1:0] = f[1:0];
      prot = allow[i[5:3]][i[2:0]] ? g : f;
      bus(1'b0, 6'h10, 8'h0);
      chk("protection", 16'(q), 16'(prot));
    end
    $display("test protection transitions done");
    for (int i = 0; i < 40; i++) begin
      s = $random(seed);
      specialMode <= s[0];
      prot = s[15:8] & 8'hBF;
      pulse(NVL, 16'(prot));
      cfg = s[7:0] & 8'hC0;
      bus(1'b1, 6'h0C, cfg);
      bus(1'b0, 6'h0C, 8'h0);
      chk("config", 16'(q), 16'(cfg));
      a = (s[18] ? 16'hF800 << s[17:16] : 16'h4000 + (16'h0400 << s[17:16])) - (s[19] ? 16'h2 : 16'h0);
      run_cmd(a, codes[i % 5], s[20]);
      bus(1'b1, ST, 8'h32);
      {pv, ae} = 2'b00;
      if (specialMode) fail = 0;
      rd_st();
    end
    $display("test command ranges done");
    ce <= 1'b0;
    pulse(FW, 16'h8000);
    ce <= 1'b1;
    bus(1'b1, ST, 8'h00);
    rd_st();
    pulse(FW, 16'h8000);
    bus(1'b1, ST, 8'h00);
    ae = 1;
    rd_st();
    bus(1'b1, ST, 8'h30);
    pulse(CW, 16'h0020);
    rd_st();
    bus(1'b1, ST, 8'h30);
    ae = 0;
    pulse(STOP, 16'h0);
    rd_st();
    prot = 8'hFF;
    pulse(NVL, 16'h00FF);
    pulse(FW, 16'h8000);
    pulse(CW, 16'h0020);
    bus(1'b1, ST, 8'h80);
    pulse(STOP, 16'h0);
    {cbe, cc, blank, ae} = 4'b0001;
    rd_st();
    pulse(FETCH, 16'h0);
    cbe = 1;
    pulse(FW, 16'h8002);
    pulse(CW, 16'h0020);
    bus(1'b1, ST, 8'h80);
    @(negedge clk);
    chk("blocked launch", 16'(cmdLaunch), 16'h0);
    $display("test errors done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    {cbe, cc, pv, ae, blank, fail, cfg} = {6'b110000, 8'h0};
    bus(1'b0, 6'h10, 8'h0);
    chk("protection", 16'(q), 16'h00A4);
    rd_st();
    $display("test second reset done");
    print_verdict();
  end
endmodule : fps_flash_protect_status_tb
